// ---- verilog/serial_port_data_buffers.sv ----
// Purpose: receive queue, transmit buffer and shifters of a serial port, APB registers
// Assumes: one clock pclk, rxd asynchronous, baud register = pclk cycles per bit
// Notes: upper bits of short characters are dropped on send and zeroed on receive
// Contract
// - two-entry first-in first-out receive queue
// - reading receive buffer advances queue and flags
// - low byte read returns oldest character
// - receive flag shows unread data; disable flushes
// - overflow: queue full, shifter full, new start
// - frame error reflects first stop bit only
// - parity error only when checking enabled, or for the LIN identifier
// - LIN mode: parity reports identifier check
// - LIN mode bit 8: identifier zero, data one
// - error flags unused as synchronous master
// - transmit writes ignored while buffer full
// - buffer moves to empty shifter, then sent
// - short characters: upper bits ignored, zeroed
// - buffer-empty flag: reset set, write clears
`timescale 1ns/1ps
module serial_port_data_buffers #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic pclk, // bus clock, 10 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [ADDR_WIDTH-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic rxd, // serial receive line
  output logic txd, // serial transmit line
  output logic irq // interrupt, level, active high
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pop_ok;
    logic txd;
    logic irq;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [7:0] debug;
    logic [7:0] event_ctrl;
    logic [7:0] tx_pulse;
    logic [7:0] rx_pulse;
    logic [15:0] baud;
    serial_port_pkg::rx_entry_t [1:0] fifo;
    logic [1:0] count;
    serial_port_pkg::rx_entry_t hold;
    logic hold_valid;
    logic overflow;
    serial_port_pkg::rx_state_t rx_state;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic rx_par;
    logic [1:0] lin_seq;
    logic [8:0] tx_buf;
    logic tx_buf_valid;
    logic tx_wait_high;
    logic tx_bit8;
    serial_port_pkg::tx_state_t tx_state;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    logic tx_par;
    logic tx_stop2;
    logic tx_complete;
    logic [serial_port_pkg::INT_BITS-1:0] int_status;
    logic [serial_port_pkg::INT_BITS-1:0] int_enable;
  } core_t;

  core_t q;
  core_t next_q;

  function automatic logic [3:0] char_bits(input logic [2:0] size);
    logic [3:0] n;
    n = 4'd8;
    if (size <= 3'h3) begin
      n = {1'b0, size} + 4'd5;
    end else if (size == serial_port_pkg::SIZE_NINE_LOW_FIRST ||
                 size == serial_port_pkg::SIZE_NINE_HIGH_FIRST) begin
      n = 4'd9;
    end
    return n;
  endfunction : char_bits

  function automatic logic [8:0] mask_bits(input logic [8:0] d, input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1ff >> (4'd9 - n);
    return d & m;
  endfunction : mask_bits

  // protected identifier parity check, bits 7:6 against the id
  function automatic logic pid_bad(input logic [7:0] d);
    logic p0;
    logic p1;
    p0 = d[0] ^ d[1] ^ d[2] ^ d[4];
    p1 = ~(d[1] ^ d[3] ^ d[4] ^ d[5]);
    return (p0 != d[6]) || (p1 != d[7]);
  endfunction : pid_bad

  logic [3:0] nbits;
  logic nine_low_first;
  logic parity_on;
  logic parity_odd;
  logic lin_mode;
  logic spi_master;
  logic [15:0] period;
  logic [5:0] index;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rdata;
  logic pop;
  logic [serial_port_pkg::INT_BITS-1:0] events;
  logic [serial_port_pkg::INT_BITS-1:0] clears;
  serial_port_pkg::rx_entry_t entry;
  logic rx_line;

  always_comb begin
    nbits = char_bits(q.ctrl_c[2:0]);
    nine_low_first = q.ctrl_c[2:0] == serial_port_pkg::SIZE_NINE_LOW_FIRST;
    parity_on = q.ctrl_c[5:4] == serial_port_pkg::PARITY_EVEN ||
                q.ctrl_c[5:4] == serial_port_pkg::PARITY_ODD;
    parity_odd = q.ctrl_c[5:4] == serial_port_pkg::PARITY_ODD;
    lin_mode = q.ctrl_b[2:1] == serial_port_pkg::RX_MODE_LIN;
    spi_master = q.ctrl_c[7:6] == serial_port_pkg::COMM_SPI_MASTER;
    period = (q.baud == 16'h0000) ? 16'h0001 : q.baud;
    index = paddr[7:2];
    setup = psel && !penable;
    access = psel && penable && q.pready;
    rx_line = q.sync2;
    mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_WIDTH-1:2] <= 6'h12) &&
             (index != 6'h0a) && (index != 6'h0f);
    rdata = 32'h0000_0000;
    case (index)
      serial_port_pkg::REG_RX_LOW: rdata[7:0] = q.fifo[0].data[7:0];
      serial_port_pkg::REG_RX_HIGH: begin
        rdata[serial_port_pkg::RXH_COMPLETE] = q.count != 2'h0;
        rdata[serial_port_pkg::RXH_OVERFLOW] = q.overflow && !spi_master;
        rdata[serial_port_pkg::RXH_FRAME] = q.fifo[0].frame_error && !spi_master;
        rdata[serial_port_pkg::RXH_PARITY] = q.fifo[0].parity_error && !spi_master;
        rdata[0] = q.fifo[0].data[8];
      end
      serial_port_pkg::REG_TX_LOW: rdata[7:0] = q.tx_buf[7:0];
      serial_port_pkg::REG_STATUS: begin
        rdata[serial_port_pkg::RXH_COMPLETE] = q.count != 2'h0;
        rdata[serial_port_pkg::ST_TX_COMPLETE] = q.tx_complete;
        rdata[serial_port_pkg::ST_TX_EMPTY] = !q.tx_buf_valid;
      end
      serial_port_pkg::REG_CTRL_A: rdata[7:0] = q.ctrl_a;
      serial_port_pkg::REG_CTRL_B: rdata[7:0] = q.ctrl_b;
      serial_port_pkg::REG_CTRL_C: rdata[7:0] = q.ctrl_c;
      serial_port_pkg::REG_BAUD_LO: rdata[7:0] = q.baud[7:0];
      serial_port_pkg::REG_BAUD_HI: rdata[7:0] = q.baud[15:8];
      serial_port_pkg::REG_DEBUG: rdata[7:0] = q.debug;
      serial_port_pkg::REG_EVENT: rdata[7:0] = q.event_ctrl;
      serial_port_pkg::REG_TX_PULSE: rdata[7:0] = q.tx_pulse;
      serial_port_pkg::REG_RX_PULSE: rdata[7:0] = q.rx_pulse;
      serial_port_pkg::REG_INT_STATUS: rdata[serial_port_pkg::INT_BITS-1:0] = q.int_status;
      serial_port_pkg::REG_INT_ENABLE: rdata[serial_port_pkg::INT_BITS-1:0] = q.int_enable;
      default: rdata = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rdata = 32'h0000_0000;
    end

    next_q = q;
    events = '0;
    clears = '0;
    entry = '0;
    next_q.sync1 = rxd;
    next_q.sync2 = q.sync1;

    // bus slave: answer in the first access cycle
    next_q.pready = setup;
    if (setup) begin
      next_q.prdata = rdata;
      next_q.pslverr = !mapped;
      next_q.pop_ok = q.count != 2'h0;
    end

    // queue advances on the read that completes a character
    pop = access && !pwrite && q.pop_ok && mapped &&
          (nine_low_first ? index == serial_port_pkg::REG_RX_HIGH
                          : index == serial_port_pkg::REG_RX_LOW);
    if (pop) begin
      next_q.fifo[0] = q.fifo[1];
      next_q.overflow = 1'b0;
      if (q.hold_valid) begin
        next_q.fifo[1] = q.hold;
        next_q.hold_valid = 1'b0;
      end else begin
        next_q.count = q.count - 2'h1;
      end
    end

    if (access && pwrite && mapped && pstrb[0]) begin
      case (index)
        serial_port_pkg::REG_TX_LOW: begin
          if (!q.tx_buf_valid) begin
            next_q.tx_buf = mask_bits({q.tx_bit8, pwdata[7:0]}, nbits);
            next_q.tx_buf_valid = 1'b1;
            next_q.tx_wait_high = nine_low_first;
          end
        end
        serial_port_pkg::REG_TX_HIGH: begin
          next_q.tx_bit8 = pwdata[0];
          if (q.tx_wait_high) begin
            next_q.tx_buf[8] = pwdata[0];
            next_q.tx_wait_high = 1'b0;
          end
        end
        serial_port_pkg::REG_STATUS: begin
          if (pwdata[serial_port_pkg::ST_TX_COMPLETE]) begin
            next_q.tx_complete = 1'b0;
          end
        end
        serial_port_pkg::REG_CTRL_A: next_q.ctrl_a = pwdata[7:0];
        serial_port_pkg::REG_CTRL_B: next_q.ctrl_b = pwdata[7:0] & 8'hdf;
        serial_port_pkg::REG_CTRL_C: next_q.ctrl_c = pwdata[7:0];
        serial_port_pkg::REG_BAUD_LO: next_q.baud[7:0] = pwdata[7:0];
        serial_port_pkg::REG_BAUD_HI: next_q.baud[15:8] = pwdata[7:0];
        serial_port_pkg::REG_DEBUG: next_q.debug = pwdata[7:0] & 8'h01;
        serial_port_pkg::REG_EVENT: next_q.event_ctrl = pwdata[7:0] & 8'h01;
        serial_port_pkg::REG_TX_PULSE: next_q.tx_pulse = pwdata[7:0];
        serial_port_pkg::REG_RX_PULSE: next_q.rx_pulse = pwdata[7:0] & 8'h7f;
        serial_port_pkg::REG_INT_ENABLE: begin
          next_q.int_enable = pwdata[serial_port_pkg::INT_BITS-1:0];
        end
        serial_port_pkg::REG_INT_CLEAR: clears = pwdata[serial_port_pkg::INT_BITS-1:0];
        default: next_q.ctrl_a = q.ctrl_a;
      endcase
    end

    // receiver
    if (q.rx_cnt != 16'h0000) begin
      next_q.rx_cnt = q.rx_cnt - 16'h0001;
    end
    case (q.rx_state)
      serial_port_pkg::RX_IDLE: begin
        if (!rx_line) begin
          next_q.rx_state = serial_port_pkg::RX_START;
          next_q.rx_cnt = period >> 1;
          if (q.count == 2'h2 && q.hold_valid && !spi_master) begin
            next_q.overflow = 1'b1;
            events[serial_port_pkg::INT_OVERFLOW] = 1'b1;
          end
        end
      end
      serial_port_pkg::RX_START: begin
        if (q.rx_cnt == 16'h0000) begin
          next_q.rx_state = rx_line ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
          next_q.rx_cnt = period - 16'h0001;
          next_q.rx_bit = 4'h0;
          next_q.rx_shift = 9'h000;
        end
      end
      serial_port_pkg::RX_DATA: begin
        if (q.rx_cnt == 16'h0000) begin
          next_q.rx_shift[q.rx_bit] = rx_line;
          next_q.rx_bit = q.rx_bit + 4'h1;
          next_q.rx_cnt = period - 16'h0001;
          if (q.rx_bit == nbits - 4'h1) begin
            next_q.rx_state = parity_on ? serial_port_pkg::RX_PAR : serial_port_pkg::RX_STOP;
          end
        end
      end
      serial_port_pkg::RX_PAR: begin
        if (q.rx_cnt == 16'h0000) begin
          next_q.rx_par = rx_line;
          next_q.rx_cnt = period - 16'h0001;
          next_q.rx_state = serial_port_pkg::RX_STOP;
        end
      end
      serial_port_pkg::RX_STOP: begin
        if (q.rx_cnt == 16'h0000) begin
          // only the first stop bit is sampled
          entry.data = mask_bits(q.rx_shift, nbits);
          entry.frame_error = !rx_line && !spi_master;
          entry.parity_error = parity_on && !spi_master &&
                               (q.rx_par != ((^entry.data) ^ parity_odd));
          if (lin_mode) begin
            entry.data[8] = q.lin_seq != 2'h1;
            if (q.lin_seq == 2'h1) begin
              entry.parity_error = pid_bad(entry.data[7:0]) && !spi_master;
            end
            if (q.lin_seq != 2'h0) begin
              next_q.lin_seq = q.lin_seq - 2'h1;
            end
            if (entry.frame_error && entry.data[7:0] == serial_port_pkg::BREAK_CHAR) begin
              next_q.lin_seq = 2'h2;
            end
          end
          if (next_q.count != 2'h2) begin
            next_q.fifo[next_q.count[0]] = entry;
            next_q.count = next_q.count + 2'h1;
          end else begin
            next_q.hold = entry;
            next_q.hold_valid = 1'b1;
          end
          events[serial_port_pkg::INT_RX_COMPLETE] = 1'b1;
          events[serial_port_pkg::INT_FRAME] = entry.frame_error;
          next_q.rx_state = serial_port_pkg::RX_IDLE;
        end
      end
      default: next_q.rx_state = serial_port_pkg::RX_IDLE;
    endcase
    if (!q.ctrl_b[serial_port_pkg::CB_RX_ENABLE]) begin
      next_q.count = 2'h0;
      next_q.hold_valid = 1'b0;
      next_q.overflow = 1'b0;
      next_q.lin_seq = 2'h0;
      next_q.rx_state = serial_port_pkg::RX_IDLE;
    end

    // transmitter
    if (q.tx_cnt != 16'h0000) begin
      next_q.tx_cnt = q.tx_cnt - 16'h0001;
    end
    case (q.tx_state)
      serial_port_pkg::TX_IDLE: begin
        next_q.txd = 1'b1;
        if (q.ctrl_b[serial_port_pkg::CB_TX_ENABLE] && q.tx_buf_valid && !q.tx_wait_high &&
            !(access && pwrite && index == serial_port_pkg::REG_TX_HIGH && nine_low_first)) begin
          next_q.tx_shift = q.tx_buf;
          next_q.tx_par = (^q.tx_buf) ^ parity_odd;
          next_q.tx_buf_valid = 1'b0;
          next_q.tx_state = serial_port_pkg::TX_START;
          next_q.tx_cnt = period - 16'h0001;
          next_q.txd = 1'b0;
          events[serial_port_pkg::INT_TX_EMPTY] = 1'b1;
        end
      end
      serial_port_pkg::TX_START: begin
        if (q.tx_cnt == 16'h0000) begin
          next_q.txd = q.tx_shift[0];
          next_q.tx_bit = 4'h0;
          next_q.tx_cnt = period - 16'h0001;
          next_q.tx_state = serial_port_pkg::TX_DATA;
        end
      end
      serial_port_pkg::TX_DATA: begin
        if (q.tx_cnt == 16'h0000) begin
          next_q.tx_cnt = period - 16'h0001;
          next_q.tx_shift = q.tx_shift >> 1;
          next_q.tx_bit = q.tx_bit + 4'h1;
          next_q.txd = q.tx_shift[1];
          if (q.tx_bit == nbits - 4'h1) begin
            next_q.tx_stop2 = q.ctrl_c[serial_port_pkg::CC_STOP_BITS];
            next_q.tx_state = parity_on ? serial_port_pkg::TX_PAR : serial_port_pkg::TX_STOP;
            next_q.txd = parity_on ? q.tx_par : 1'b1;
          end
        end
      end
      serial_port_pkg::TX_PAR: begin
        if (q.tx_cnt == 16'h0000) begin
          next_q.tx_cnt = period - 16'h0001;
          next_q.txd = 1'b1;
          next_q.tx_state = serial_port_pkg::TX_STOP;
        end
      end
      serial_port_pkg::TX_STOP: begin
        if (q.tx_cnt == 16'h0000) begin
          next_q.tx_cnt = period - 16'h0001;
          next_q.tx_stop2 = 1'b0;
          if (!q.tx_stop2) begin
            next_q.tx_state = serial_port_pkg::TX_IDLE;
            if (!next_q.tx_buf_valid) begin
              next_q.tx_complete = 1'b1;
              events[serial_port_pkg::INT_TX_COMPLETE] = 1'b1;
            end
          end
        end
      end
      default: next_q.tx_state = serial_port_pkg::TX_IDLE;
    endcase

    // sticky interrupt status: a new event beats its clear
    next_q.int_status = (q.int_status & ~clears) | events;
    next_q.irq = |(next_q.int_status & next_q.int_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.txd <= 1'b1;
      q.baud <= serial_port_pkg::BAUD_RESET;
      q.ctrl_b <= serial_port_pkg::BYTE_RESET;
      q.rx_state <= serial_port_pkg::RX_IDLE;
      q.tx_state <= serial_port_pkg::TX_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign txd = q.txd;
  assign irq = q.irq;

endmodule : serial_port_data_buffers

// ---- verilog/serial_port_pkg.sv ----
// Purpose: shared constants and types for the serial port data buffers
// Assumes: byte registers on a 32-bit APB, one register per aligned word
// Notes: register indices are word numbers; byte address = index * 4
package serial_port_pkg;

  // register indices (byte address is four times the index)
  localparam logic [5:0] REG_RX_LOW = 6'h00;
  localparam logic [5:0] REG_RX_HIGH = 6'h01;
  localparam logic [5:0] REG_TX_LOW = 6'h02;
  localparam logic [5:0] REG_TX_HIGH = 6'h03;
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_CTRL_A = 6'h05;
  localparam logic [5:0] REG_CTRL_B = 6'h06;
  localparam logic [5:0] REG_CTRL_C = 6'h07;
  localparam logic [5:0] REG_BAUD_LO = 6'h08;
  localparam logic [5:0] REG_BAUD_HI = 6'h09;
  localparam logic [5:0] REG_DEBUG = 6'h0b;
  localparam logic [5:0] REG_EVENT = 6'h0c;
  localparam logic [5:0] REG_TX_PULSE = 6'h0d;
  localparam logic [5:0] REG_RX_PULSE = 6'h0e;
  localparam logic [5:0] REG_INT_STATUS = 6'h10;
  localparam logic [5:0] REG_INT_ENABLE = 6'h11;
  localparam logic [5:0] REG_INT_CLEAR = 6'h12;

  // field positions
  localparam int RXH_COMPLETE = 7;
  localparam int RXH_OVERFLOW = 6;
  localparam int RXH_FRAME = 2;
  localparam int RXH_PARITY = 1;
  localparam int ST_TX_COMPLETE = 6;
  localparam int ST_TX_EMPTY = 5;
  localparam int CB_RX_ENABLE = 7;
  localparam int CB_TX_ENABLE = 6;
  localparam int CC_STOP_BITS = 3;

  // field codes
  localparam logic [1:0] RX_MODE_LIN = 2'h3;
  localparam logic [1:0] COMM_SPI_MASTER = 2'h3;
  localparam logic [2:0] SIZE_NINE_LOW_FIRST = 3'h6;
  localparam logic [2:0] SIZE_NINE_HIGH_FIRST = 3'h7;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] PARITY_ODD = 2'h3;
  localparam logic [7:0] BREAK_CHAR = 8'h00;

  // reset values
  localparam logic [15:0] BAUD_RESET = 16'h0010;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // interrupt event bits
  localparam int INT_RX_COMPLETE = 0;
  localparam int INT_TX_COMPLETE = 1;
  localparam int INT_TX_EMPTY = 2;
  localparam int INT_OVERFLOW = 3;
  localparam int INT_FRAME = 4;
  localparam int INT_BITS = 5;

  // one receive queue entry: character plus its own flags
  typedef struct packed {
    logic [8:0] data;
    logic frame_error;
    logic parity_error;
  } rx_entry_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;

endpackage : serial_port_pkg

// ---- test/serial_port_assertions.sv ----
// Purpose: port checks of the serial port data buffers
// Assumes: register index is paddr[7:2]
// Notes: control shadows follow completed writes
`timescale 1ns/1ps
module serial_port_assertions #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [ADDR_WIDTH-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [3:0] pstrb, // strobes
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic rxd, // serial in
  input wire logic txd, // serial out
  input wire logic irq // interrupt
);
  logic [7:0] cb;
  logic [7:0] cc;
  logic tx_seen;
  logic [5:0] idx;
  logic done;
  logic wr;
  logic rd;
  assign idx = paddr[7:2];
  assign done = psel && penable && pready;
  assign wr = done && pwrite && pstrb[0] && !pslverr;
  assign rd = done && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb <= 8'h00;
      cc <= 8'h00;
      tx_seen <= 1'b0;
    end else begin
      if (wr && idx == serial_port_pkg::REG_CTRL_B) cb <= pwdata[7:0];
      if (wr && idx == serial_port_pkg::REG_CTRL_C) cc <= pwdata[7:0];
      if (wr && idx == serial_port_pkg::REG_TX_LOW) tx_seen <= 1'b1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    psel && penable && pready;
  endsequence
  a_apb_answer: assert property (setup_s |=> answer_s ##1 !pready)
    else $error("apb access not answered in one cycle");
  a_unmapped_err: assert property (done && idx == 6'h0a |-> pslverr)
    else $error("unmapped access without error");
  a_empty_reset: assert property (rd && idx == serial_port_pkg::REG_STATUS && !tx_seen |->
    prdata[serial_port_pkg::ST_TX_EMPTY]) else $error("tx buffer not empty before any write");
  a_flush_clears: assert property (rd && idx == serial_port_pkg::REG_RX_HIGH &&
    !cb[serial_port_pkg::CB_RX_ENABLE] && !$past(cb[serial_port_pkg::CB_RX_ENABLE], 2) |->
    prdata[7:6] == 2'h0)
    else $error("receive flags set while receiver off");
  a_parity_off: assert property (rd && idx == serial_port_pkg::REG_RX_HIGH && !cc[5] &&
    cb[2:1] != serial_port_pkg::RX_MODE_LIN |-> !prdata[serial_port_pkg::RXH_PARITY])
    else $error("parity flag with checking off");
  a_master_flags: assert property (rd && idx == serial_port_pkg::REG_RX_HIGH &&
    cc[7:6] == serial_port_pkg::COMM_SPI_MASTER |-> prdata[6] == 1'b0 && prdata[2:1] == 2'h0)
    else $error("error flags in sync master mode");
  a_short_zero: assert property (rd && idx == serial_port_pkg::REG_RX_LOW &&
    cc[7:6] == 2'h0 && cc[2:0] < 3'h3 |-> (prdata[7:0] >> (cc[2:0] + 3'h5)) == 8'h00)
    else $error("upper bits of short character not zero");
  a_tx_cause: assert property ($fell(txd) |-> tx_seen && cb[serial_port_pkg::CB_TX_ENABLE])
    else $error("transmit without data or enable");
endmodule : serial_port_assertions

bind serial_port_data_buffers serial_port_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));

// ---- test/serial_far_end.sv ----
// Purpose: remote serial transceiver on the port's lines
// Assumes: bit time of BIT_CYCLES clocks, nine-bit capture
// Notes: line idles high between frames
`timescale 1ns/1ps
module serial_far_end #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic pclk, // bit timing clock
  output logic rxd, // line into the port
  input wire logic txd // line out of the port
);
  logic [8:0] got[$];
  initial rxd = 1'b1;
  task automatic bit_out(input logic v);
    rxd <= v;
    repeat (BIT_CYCLES) @(posedge pclk);
  endtask : bit_out
  // start, data lsb first, optional parity, stop, one idle bit
  task automatic send(input logic [8:0] d, input int n, input logic [1:0] pm,
                      input logic bad, input logic stop);
    logic p;
    p = pm[0] ^ bad;
    bit_out(1'b0);
    for (int i = 0; i < n; i++) begin
      bit_out(d[i]);
      p = p ^ d[i];
    end
    if (pm[1]) bit_out(p);
    bit_out(stop);
    bit_out(1'b1);
  endtask : send
  initial begin
    logic [8:0] v;
    forever begin
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYCLES) @(posedge pclk);
        v[i] = txd;
      end
      got.push_back(v);
    end
  end
endmodule : serial_far_end

// ---- test/tb_serial_port_data_buffers.sv ----
// Purpose: self-checking bench of the serial port data buffers
// Assumes: baud set to 4 clocks per bit
// Notes: rows cover frame formats, hand tests the rest
`timescale 1ns/1ps
module tb_serial_port_data_buffers;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  logic er;
  int fails, compares, t;
  typedef struct {
    logic [7:0] cc; logic [8:0] d; int n; logic bad; logic stop; logic [7:0] hi; logic [7:0] lo;
  } row_t;
  row_t rows[7];
  serial_port_data_buffers DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  serial_far_end #(.BIT_CYCLES(4)) far (.pclk(pclk), .rxd(rxd), .txd(txd));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so that the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input string nm, input logic [5:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 32'h0);
    check(nm, {24'h0, e}, rv);
  endtask : rdchk
  task automatic wait_rx;
    int n;
    n = 0;
    do begin
      apb(1'b0, serial_port_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rv[7] !== 1'b1 && n < 200);
  endtask : wait_rx
  task automatic irqchk(input logic e);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, e}, {31'h0, irq});
  endtask : irqchk
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    print_verdict();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    rows = '{'{8'h03, 9'h0a5, 8, 1'b0, 1'b1, 8'h80, 8'ha5}, '{8'h03, 9'h03c, 8, 1'b0, 1'b0, 8'h84,
      8'h3c}, '{8'h00, 9'h01f, 5, 1'b0, 1'b1, 8'h80, 8'h1f}, '{8'h23, 9'h055, 8, 1'b1, 1'b1, 8'h82,
      8'h55}, '{8'h33, 9'h055, 8, 1'b0, 1'b1, 8'h80, 8'h55}, '{8'h0b, 9'h081, 8, 1'b0, 1'b1, 8'h80,
      8'h81}, '{8'h07, 9'h1c3, 9, 1'b0, 1'b1, 8'h81, 8'hc3}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("status", serial_port_pkg::REG_STATUS, 8'h20);
    rdchk("rx_high", serial_port_pkg::REG_RX_HIGH, 8'h00);
    rdchk("rx_low", serial_port_pkg::REG_RX_LOW, 8'h00);
    rdchk("baud", serial_port_pkg::REG_BAUD_LO, serial_port_pkg::BAUD_RESET[7:0]);
    apb(1'b1, 6'h0a, 32'h1);
    check("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, serial_port_pkg::REG_BAUD_LO, 32'h4);
    apb(1'b1, serial_port_pkg::REG_BAUD_HI, 32'h0);
    apb(1'b1, serial_port_pkg::REG_CTRL_B, 32'hc0);
    foreach (rows[i]) begin
      apb(1'b1, serial_port_pkg::REG_CTRL_C, {24'h0, rows[i].cc});
      far.send(rows[i].d, rows[i].n, rows[i].cc[5:4], rows[i].bad, rows[i].stop);
      wait_rx();
      rdchk("row_high", serial_port_pkg::REG_RX_HIGH, rows[i].hi);
      rdchk("row_low", serial_port_pkg::REG_RX_LOW, rows[i].lo);
    end
    apb(1'b1, serial_port_pkg::REG_CTRL_C, 32'h03);
    for (int i = 1; i < 5; i++) far.send(9'(i * 17), 8, 2'h0, 1'b0, 1'b1);
    rdchk("ovf_high", serial_port_pkg::REG_RX_HIGH, 8'hc0);
    rdchk("ovf_low", serial_port_pkg::REG_RX_LOW, 8'h11);
    rdchk("next_high", serial_port_pkg::REG_RX_HIGH, 8'h80);
    rdchk("next_low", serial_port_pkg::REG_RX_LOW, 8'h22);
    apb(1'b1, serial_port_pkg::REG_CTRL_B, 32'h40);
    rdchk("flushed", serial_port_pkg::REG_RX_HIGH, 8'h00);
    apb(1'b1, serial_port_pkg::REG_INT_CLEAR, 32'h1f);
    apb(1'b1, serial_port_pkg::REG_CTRL_B, 32'hc0);
    apb(1'b1, serial_port_pkg::REG_INT_ENABLE, 32'h1);
    far.send(9'h05e, 8, 2'h0, 1'b0, 1'b1);
    wait_rx();
    rdchk("int_status", serial_port_pkg::REG_INT_STATUS, 8'h01);
    irqchk(1'b1);
    apb(1'b1, serial_port_pkg::REG_INT_ENABLE, 32'h0);
    irqchk(1'b0);
    apb(1'b1, serial_port_pkg::REG_INT_ENABLE, 32'h1);
    irqchk(1'b1);
    apb(1'b1, serial_port_pkg::REG_INT_CLEAR, 32'h1);
    irqchk(1'b0);
    apb(1'b1, serial_port_pkg::REG_TX_LOW, 32'h5a);
    apb(1'b1, serial_port_pkg::REG_TX_LOW, 32'ha6);
    apb(1'b1, serial_port_pkg::REG_TX_LOW, 32'h0f);
    rdchk("tx_full", serial_port_pkg::REG_STATUS, 8'h80);
    t = 0;
    while (far.got.size() < 2 && t < 400) begin
      @(posedge pclk);
      t++;
    end
    repeat (100) @(posedge pclk);
    check("tx_count", 32'h2, 32'(far.got.size()));
    // ninth sample of an 8-bit frame is its stop bit
    check("tx_first", 32'h15a, {23'h0, far.got[0]});
    check("tx_second", 32'h1a6, {23'h0, far.got[1]});
    apb(1'b1, serial_port_pkg::REG_CTRL_C, 32'h07);
    apb(1'b1, serial_port_pkg::REG_TX_HIGH, 32'h1);
    apb(1'b1, serial_port_pkg::REG_TX_LOW, 32'h3c);
    repeat (100) @(posedge pclk);
    apb(1'b1, serial_port_pkg::REG_CTRL_C, 32'h06);
    apb(1'b1, serial_port_pkg::REG_TX_LOW, 32'hc3);
    apb(1'b1, serial_port_pkg::REG_TX_HIGH, 32'h0);
    repeat (100) @(posedge pclk);
    check("tx_nine_high", 32'h13c, {23'h0, far.got[2]});
    check("tx_nine_low", 32'h0c3, {23'h0, far.got[3]});
    apb(1'b1, serial_port_pkg::REG_CTRL_C, 32'hc3);
    rdchk("master_high", serial_port_pkg::REG_RX_HIGH, 8'h80);
    print_verdict();
  end
endmodule : tb_serial_port_data_buffers
